// ### hdl/rot_sub_skip_map.vh
// Overview of operation
// - Return-with-immediate pops the program counter, loads the immediate into the accumulator, no flags.
// - Return-from-interrupt with no request pending pops the program counter and sets global interrupt enable, no flags.
// - A pending interrupt at return-from-interrupt is serviced before the main program resumes.
// - Rotate left, bit 7 into bit 0, to memory or accumulator, no flags.
// - Rotate left through carry: old carry to bit 0, bit 7 to carry.
// - Rotate right, bit 0 into bit 7, to memory or accumulator, no flags.
// - Rotate right through carry: old carry to bit 7, bit 0 to carry.
// - Subtract with borrow: acc minus memory minus inverted carry, updates all four flags.
// - Subtraction carry is an inverted borrow: zero when negative, one otherwise.
// - Plain subtract of memory or immediate, to accumulator or memory, updates all four flags.
// - Decrement memory and write back, skip next when zero, no flags.
// - Decrement to accumulator only, memory kept, skip when accumulator zero.
// - Increment memory and write back, skip next when zero, no flags.
// - Increment to accumulator only, memory kept, skip when accumulator zero.
// - Set byte writes FFH to the addressed memory byte, no flags.
// - Set bit forces only the selected memory bit to one, no flags.
// - Skip next instruction when the selected memory bit is nonzero.
// - Every taken skip takes two instruction cycles through an inserted dummy cycle.
`ifndef ROT_SUB_SKIP_MAP_VH
`define ROT_SUB_SKIP_MAP_VH

// ----------------------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------------------
`define OFS_EXEC 5'h00
`define OFS_ACC 5'h04
`define OFS_STATUS 5'h08
`define OFS_PC 5'h0C
`define OFS_MEM_ADDR 5'h10
`define OFS_MEM_DATA 5'h14
`define OFS_STACK_PTR 5'h18
`define OFS_STACK_PUSH 5'h1C

// ----------------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------------
`define EXEC_OP_LSB 0
`define EXEC_BIT_LSB 5
`define EXEC_IMM_LSB 8
`define EXEC_ADDR_LSB 16
`define ST_C 0
`define ST_AC 1
`define ST_Z 2
`define ST_OV 3
`define ST_GIE 4
`define ST_BUSY 8
`define ST_SKIP 9

// ----------------------------------------------------------------------------
// Reset values and constants
// ----------------------------------------------------------------------------
`define ACC_RST 8'h00
`define FLAGS_RST 1'b0
`define SET_BYTE_VAL 8'hFF
`define CYCLE_DIV_DEF 8'h04

// ----------------------------------------------------------------------------
// Opcodes
// ----------------------------------------------------------------------------
`define OP_RETURN_LOAD_IMM 5'h00
`define OP_RETURN_FROM_IRQ 5'h01
`define OP_ROTATE_LEFT 5'h02
`define OP_ROTATE_LEFT_TO_ACC 5'h03
`define OP_ROTATE_LEFT_THRU_CARRY 5'h04
`define OP_ROTATE_LEFT_THRU_CARRY_TO_ACC 5'h05
`define OP_ROTATE_RIGHT 5'h06
`define OP_ROTATE_RIGHT_TO_ACC 5'h07
`define OP_ROTATE_RIGHT_THRU_CARRY 5'h08
`define OP_ROTATE_RIGHT_THRU_CARRY_TO_ACC 5'h09
`define OP_SUBTRACT_WITH_BORROW 5'h0A
`define OP_SUBTRACT_WITH_BORROW_TO_MEM 5'h0B
`define OP_SUBTRACT_MEM 5'h0C
`define OP_SUBTRACT_TO_MEM 5'h0D
`define OP_SUBTRACT_IMM 5'h0E
`define OP_DECREMENT_SKIP_ZERO 5'h0F
`define OP_DECREMENT_SKIP_ZERO_TO_ACC 5'h10
`define OP_INCREMENT_SKIP_ZERO 5'h11
`define OP_INCREMENT_SKIP_ZERO_TO_ACC 5'h12
`define OP_SET_BYTE 5'h13
`define OP_SET_BIT 5'h14
`define OP_SKIP_BIT_NONZERO 5'h15

`endif

// ### hdl/rot_sub_alu.v
`timescale 1ns/1ps
`default_nettype none
`include "rot_sub_skip_map.vh"

module rot_sub_alu (
  input wire [4:0] op,
  input wire [7:0] acc,
  input wire [7:0] mem,
  input wire [7:0] imm,
  input wire [2:0] bit_sel,
  input wire carry,
  output reg [7:0] result,
  output reg wr_acc,
  output reg wr_mem,
  output reg c_out,
  output reg upd_c,
  output reg upd_arith,
  output reg skip,
  output wire ac_out,
  output wire z_out,
  output wire ov_out
);

  // --------------------------------------------------------------------------
  // Shared subtractor
  // --------------------------------------------------------------------------
  // One adder of a plus inverted b serves every subtract; carry out is no-borrow.
  reg [7:0] sub_b;
  reg sub_cin;
  wire [8:0] diff;
  wire [4:0] diff_lo;
  wire [7:0] inc_val;
  wire [7:0] dec_val;

  assign diff = {1'b0, acc} + {1'b0, ~sub_b} + {8'h00, sub_cin};
  assign diff_lo = {1'b0, acc[3:0]} + {1'b0, ~sub_b[3:0]} + {4'h0, sub_cin};
  assign ac_out = diff_lo[4];
  assign z_out = (diff[7:0] == 8'h00);
  assign ov_out = (acc[7] ^ sub_b[7]) & (acc[7] ^ diff[7]);
  assign inc_val = mem + 8'h01;
  assign dec_val = mem - 8'h01;

  // --------------------------------------------------------------------------
  // Operation decode
  // --------------------------------------------------------------------------
  always @* begin
    sub_b = mem;
    sub_cin = 1'b1;
    result = 8'h00;
    wr_acc = 1'b0;
    wr_mem = 1'b0;
    c_out = carry;
    upd_c = 1'b0;
    upd_arith = 1'b0;
    skip = 1'b0;
    case (op)
      `OP_RETURN_LOAD_IMM: begin
        result = imm;
        wr_acc = 1'b1;
      end
      `OP_ROTATE_LEFT, `OP_ROTATE_LEFT_TO_ACC: begin
        result = {mem[6:0], mem[7]};
        wr_mem = (op == `OP_ROTATE_LEFT);
        wr_acc = ~wr_mem;
      end
      `OP_ROTATE_LEFT_THRU_CARRY, `OP_ROTATE_LEFT_THRU_CARRY_TO_ACC: begin
        result = {mem[6:0], carry};
        c_out = mem[7];
        upd_c = 1'b1;
        wr_mem = (op == `OP_ROTATE_LEFT_THRU_CARRY);
        wr_acc = ~wr_mem;
      end
      `OP_ROTATE_RIGHT, `OP_ROTATE_RIGHT_TO_ACC: begin
        result = {mem[0], mem[7:1]};
        wr_mem = (op == `OP_ROTATE_RIGHT);
        wr_acc = ~wr_mem;
      end
      `OP_ROTATE_RIGHT_THRU_CARRY, `OP_ROTATE_RIGHT_THRU_CARRY_TO_ACC: begin
        result = {carry, mem[7:1]};
        c_out = mem[0];
        upd_c = 1'b1;
        wr_mem = (op == `OP_ROTATE_RIGHT_THRU_CARRY);
        wr_acc = ~wr_mem;
      end
      `OP_SUBTRACT_WITH_BORROW, `OP_SUBTRACT_WITH_BORROW_TO_MEM: begin
        sub_cin = carry;
        result = diff[7:0];
        c_out = diff[8];
        upd_c = 1'b1;
        upd_arith = 1'b1;
        wr_mem = (op == `OP_SUBTRACT_WITH_BORROW_TO_MEM);
        wr_acc = ~wr_mem;
      end
      `OP_SUBTRACT_MEM, `OP_SUBTRACT_TO_MEM, `OP_SUBTRACT_IMM: begin
        if (op == `OP_SUBTRACT_IMM) begin
          sub_b = imm;
        end
        result = diff[7:0];
        c_out = diff[8];
        upd_c = 1'b1;
        upd_arith = 1'b1;
        wr_mem = (op == `OP_SUBTRACT_TO_MEM);
        wr_acc = ~wr_mem;
      end
      `OP_DECREMENT_SKIP_ZERO, `OP_DECREMENT_SKIP_ZERO_TO_ACC: begin
        result = dec_val;
        skip = (dec_val == 8'h00);
        wr_mem = (op == `OP_DECREMENT_SKIP_ZERO);
        wr_acc = ~wr_mem;
      end
      `OP_INCREMENT_SKIP_ZERO, `OP_INCREMENT_SKIP_ZERO_TO_ACC: begin
        result = inc_val;
        skip = (inc_val == 8'h00);
        wr_mem = (op == `OP_INCREMENT_SKIP_ZERO);
        wr_acc = ~wr_mem;
      end
      `OP_SET_BYTE: begin
        result = `SET_BYTE_VAL;
        wr_mem = 1'b1;
      end
      `OP_SET_BIT: begin
        result = mem | (8'h01 << bit_sel);
        wr_mem = 1'b1;
      end
      `OP_SKIP_BIT_NONZERO: begin
        skip = mem[bit_sel];
      end
      default: begin
        result = 8'h00;
      end
    endcase
  end

endmodule

`default_nettype wire

// ### hdl/rot_sub_skip_core.v
// Implementation choices: the address map and the Avalon-MM interface to the registers.
`timescale 1ns/1ps
`default_nettype none
`include "rot_sub_skip_map.vh"

module rot_sub_skip_core #(
  parameter PC_W = 11,
  parameter MA_W = 6,
  parameter SP_W = 3,
  parameter [PC_W-1:0] IRQ_VECTOR = 11'h004,
  parameter [7:0] CYCLE_DIV = `CYCLE_DIV_DEF
) (
  input wire clk,
  input wire rst_n,
  input wire [4:0] avs_address,
  input wire avs_read,
  input wire avs_write,
  input wire [31:0] avs_writedata,
  output reg [31:0] avs_readdata,
  output wire avs_waitrequest,
  input wire irq_request,
  output reg irq_ack,
  output wire global_irq_enable
);

  // --------------------------------------------------------------------------
  // States and storage
  // --------------------------------------------------------------------------
  localparam [1:0] ST_IDLE = 2'b00;
  localparam [1:0] ST_EXEC = 2'b01;
  localparam [1:0] ST_DUMMY = 2'b10;
  localparam MEM_DEPTH = 1 << MA_W;
  localparam STACK_DEPTH = 1 << SP_W;

  reg [1:0] state_reg;
  reg [31:0] exec_reg;
  reg [7:0] acc_reg;
  reg carry_flag_reg;
  reg aux_carry_flag_reg;
  reg zero_flag_reg;
  reg overflow_flag_reg;
  reg gie_reg;
  reg skip_last_reg;
  reg [PC_W-1:0] pc_reg;
  reg [MA_W-1:0] mem_addr_reg;
  reg [SP_W-1:0] sp_reg;
  reg rd_done_reg;
  reg [7:0] div_cnt_reg;
  reg cyc_en_reg;
  reg irq_meta_reg;
  reg irq_sync_reg;
  reg [7:0] data_mem [0:MEM_DEPTH-1];
  reg [PC_W-1:0] stack_mem [0:STACK_DEPTH-1];

  // --------------------------------------------------------------------------
  // Instruction fields and datapath
  // --------------------------------------------------------------------------
  wire [4:0] op;
  wire [2:0] bit_sel;
  wire [7:0] imm;
  wire [MA_W-1:0] op_addr;
  wire [7:0] mem_rd;
  wire [7:0] alu_result;
  wire alu_wr_acc;
  wire alu_wr_mem;
  wire alu_c;
  wire alu_upd_c;
  wire alu_upd_arith;
  wire alu_skip;
  wire alu_ac;
  wire alu_z;
  wire alu_ov;
  wire is_return;
  wire [SP_W-1:0] sp_pop;
  wire [PC_W-1:0] pc_top;
  wire busy;
  wire step;
  wire bus_wr;
  wire bus_rd;

  assign op = exec_reg[`EXEC_OP_LSB +: 5];
  assign bit_sel = exec_reg[`EXEC_BIT_LSB +: 3];
  assign imm = exec_reg[`EXEC_IMM_LSB +: 8];
  assign op_addr = exec_reg[`EXEC_ADDR_LSB +: MA_W];
  assign mem_rd = data_mem[op_addr];
  assign is_return = (op == `OP_RETURN_LOAD_IMM) || (op == `OP_RETURN_FROM_IRQ);
  assign sp_pop = sp_reg - {{(SP_W-1){1'b0}}, 1'b1};
  assign pc_top = stack_mem[sp_pop];
  assign busy = (state_reg != ST_IDLE);
  assign step = cyc_en_reg && (state_reg == ST_EXEC);
  assign global_irq_enable = gie_reg;

  rot_sub_alu u_alu (
    .op(op),
    .acc(acc_reg),
    .mem(mem_rd),
    .imm(imm),
    .bit_sel(bit_sel),
    .carry(carry_flag_reg),
    .result(alu_result),
    .wr_acc(alu_wr_acc),
    .wr_mem(alu_wr_mem),
    .c_out(alu_c),
    .upd_c(alu_upd_c),
    .upd_arith(alu_upd_arith),
    .skip(alu_skip),
    .ac_out(alu_ac),
    .z_out(alu_z),
    .ov_out(alu_ov)
  );

  // --------------------------------------------------------------------------
  // Bus handshake
  // --------------------------------------------------------------------------
  // Writes stall while an instruction runs, so bus and datapath never share a
  // register update. Reads take two cycles so that read data come from a flop.
  assign avs_waitrequest = avs_write ? busy : (avs_read & ~rd_done_reg);
  assign bus_wr = avs_write & ~busy;
  assign bus_rd = avs_read & ~avs_write & ~rd_done_reg;

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rd_done_reg <= 1'b0;
      avs_readdata <= 32'h00000000;
    end else begin
      rd_done_reg <= bus_rd;
      if (bus_rd) begin
        if (avs_address == `OFS_EXEC) begin
          avs_readdata <= exec_reg;
        end else if (avs_address == `OFS_ACC) begin
          avs_readdata <= {24'h000000, acc_reg};
        end else if (avs_address == `OFS_STATUS) begin
          avs_readdata <= {22'h0, skip_last_reg, busy, 3'h0, gie_reg, overflow_flag_reg,
                           zero_flag_reg, aux_carry_flag_reg, carry_flag_reg};
        end else if (avs_address == `OFS_PC) begin
          avs_readdata <= {{(32-PC_W){1'b0}}, pc_reg};
        end else if (avs_address == `OFS_MEM_ADDR) begin
          avs_readdata <= {{(32-MA_W){1'b0}}, mem_addr_reg};
        end else if (avs_address == `OFS_MEM_DATA) begin
          avs_readdata <= {24'h000000, data_mem[mem_addr_reg]};
        end else if (avs_address == `OFS_STACK_PTR) begin
          avs_readdata <= {{(32-SP_W){1'b0}}, sp_reg};
        end else begin
          avs_readdata <= 32'h00000000;
        end
      end
    end
  end

  // --------------------------------------------------------------------------
  // Instruction cycle divider and interrupt request synchroniser
  // --------------------------------------------------------------------------
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      div_cnt_reg <= 8'h00;
      cyc_en_reg <= 1'b0;
      irq_meta_reg <= 1'b0;
      irq_sync_reg <= 1'b0;
    end else begin
      irq_meta_reg <= irq_request;
      irq_sync_reg <= irq_meta_reg;
      if (div_cnt_reg >= CYCLE_DIV - 8'h01) begin
        div_cnt_reg <= 8'h00;
        cyc_en_reg <= 1'b1;
      end else begin
        div_cnt_reg <= div_cnt_reg + 8'h01;
        cyc_en_reg <= 1'b0;
      end
    end
  end

  // --------------------------------------------------------------------------
  // Data memory and stack
  // --------------------------------------------------------------------------
  // Arrays hold no reset; software loads them before use.
  always @(posedge clk) begin
    if (step && alu_wr_mem) begin
      data_mem[op_addr] <= alu_result;
    end else if (bus_wr && avs_address == `OFS_MEM_DATA) begin
      data_mem[mem_addr_reg] <= avs_writedata[7:0];
    end
    if (bus_wr && avs_address == `OFS_STACK_PUSH) begin
      stack_mem[sp_reg] <= avs_writedata[PC_W-1:0];
    end
  end

  // --------------------------------------------------------------------------
  // Execution sequencer
  // --------------------------------------------------------------------------
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= ST_IDLE;
      exec_reg <= 32'h00000000;
      acc_reg <= `ACC_RST;
      carry_flag_reg <= `FLAGS_RST;
      aux_carry_flag_reg <= `FLAGS_RST;
      zero_flag_reg <= `FLAGS_RST;
      overflow_flag_reg <= `FLAGS_RST;
      gie_reg <= `FLAGS_RST;
      skip_last_reg <= 1'b0;
      pc_reg <= {PC_W{1'b0}};
      mem_addr_reg <= {MA_W{1'b0}};
      sp_reg <= {SP_W{1'b0}};
      irq_ack <= 1'b0;
    end else begin
      irq_ack <= 1'b0;
      case (state_reg)
        ST_IDLE: begin
          if (bus_wr) begin
            if (avs_address == `OFS_EXEC) begin
              exec_reg <= avs_writedata;
              state_reg <= ST_EXEC;
            end else if (avs_address == `OFS_ACC) begin
              acc_reg <= avs_writedata[7:0];
            end else if (avs_address == `OFS_STATUS) begin
              carry_flag_reg <= avs_writedata[`ST_C];
              aux_carry_flag_reg <= avs_writedata[`ST_AC];
              zero_flag_reg <= avs_writedata[`ST_Z];
              overflow_flag_reg <= avs_writedata[`ST_OV];
              gie_reg <= avs_writedata[`ST_GIE];
            end else if (avs_address == `OFS_PC) begin
              pc_reg <= avs_writedata[PC_W-1:0];
            end else if (avs_address == `OFS_MEM_ADDR) begin
              mem_addr_reg <= avs_writedata[MA_W-1:0];
            end else if (avs_address == `OFS_STACK_PUSH) begin
              sp_reg <= sp_reg + {{(SP_W-1){1'b0}}, 1'b1};
            end
          end
        end
        ST_EXEC: begin
          if (cyc_en_reg) begin
            if (alu_wr_acc) begin
              acc_reg <= alu_result;
            end
            if (alu_upd_c) begin
              carry_flag_reg <= alu_c;
            end
            if (alu_upd_arith) begin
              aux_carry_flag_reg <= alu_ac;
              zero_flag_reg <= alu_z;
              overflow_flag_reg <= alu_ov;
            end
            skip_last_reg <= alu_skip;
            if (op == `OP_RETURN_FROM_IRQ && irq_sync_reg) begin
              // The return address stays on the stack, so the routine's own
              // return later resumes the interrupted main program.
              pc_reg <= IRQ_VECTOR;
              gie_reg <= 1'b0;
              irq_ack <= 1'b1;
            end else if (is_return) begin
              pc_reg <= pc_top;
              sp_reg <= sp_pop;
              if (op == `OP_RETURN_FROM_IRQ) begin
                gie_reg <= 1'b1;
              end
            end else if (alu_skip) begin
              pc_reg <= pc_reg + {{(PC_W-2){1'b0}}, 2'b10};
            end else begin
              pc_reg <= pc_reg + {{(PC_W-1){1'b0}}, 1'b1};
            end
            if (alu_skip) begin
              state_reg <= ST_DUMMY;
            end else begin
              state_reg <= ST_IDLE;
            end
          end
        end
        ST_DUMMY: begin
          if (cyc_en_reg) begin
            state_reg <= ST_IDLE;
          end
        end
        default: begin
          state_reg <= ST_IDLE;
        end
      endcase
    end
  end

endmodule

`default_nettype wire

// ### dv/rot_sub_skip_core_chk.sv
`timescale 1ns/1ps
`default_nettype none

module rot_sub_skip_core_chk #(
  parameter int CYCLE_DIV = 4
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [4:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [31:0] avs_readdata,
  input wire logic avs_waitrequest,
  input wire logic irq_request,
  input wire logic irq_ack,
  input wire logic global_irq_enable
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);

  // --------------------
  // Helper counters
  // --------------------
  // Since writes stall while an instruction runs, the cycles since the last
  // accepted write bound when an instruction can have taken effect.
  logic [7:0] stall_cnt;
  logic [7:0] since_wr;

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      stall_cnt <= 8'h00;
      since_wr <= 8'hFF;
    end else begin
      stall_cnt <= (avs_write && avs_waitrequest) ? stall_cnt + 8'h01 : 8'h00;
      if (avs_write && !avs_waitrequest)
        since_wr <= 8'h00;
      else if (since_wr != 8'hFF)
        since_wr <= since_wr + 8'h01;
    end
  end

  // --------------------
  // Properties
  // --------------------
  chk_read_first_wait:
    assert property ($rose(avs_read) |-> avs_waitrequest) else $error("read answered without wait state");
  chk_read_one_wait:
    assert property (avs_read && avs_waitrequest |=> !avs_waitrequest) else $error("read wait longer than one");
  chk_readdata_hold:
    assert property (!avs_read ##1 !avs_read |-> $stable(avs_readdata)) else $error("readdata moved without read");
  chk_stall_bounded:
    assert property (stall_cnt <= 2 * CYCLE_DIV + 2) else $error("write stall exceeds two instruction cycles");
  chk_ack_single:
    assert property (irq_ack |=> !irq_ack) else $error("irq_ack longer than one cycle");
  chk_ack_gie_low:
    assert property (irq_ack |-> !global_irq_enable) else $error("interrupt entry left enable set");
  chk_ack_cause:
    assert property (irq_ack |-> $past(irq_request, 2) || $past(irq_request, 3) || $past(irq_request, 4))
      else $error("irq_ack without pending request");
  chk_ack_after_exec:
    assert property (irq_ack |-> since_wr <= CYCLE_DIV + 1) else $error("irq_ack not tied to an instruction");
  chk_gie_rise_cause:
    assert property ($rose(global_irq_enable) |-> since_wr <= CYCLE_DIV + 1) else $error("enable rose on its own");
  chk_gie_fall_cause:
    assert property ($fell(global_irq_enable) |-> since_wr <= CYCLE_DIV + 1) else $error("enable fell on its own");
endmodule

bind rot_sub_skip_core rot_sub_skip_core_chk #(.CYCLE_DIV(CYCLE_DIV)) u_rot_sub_skip_core_chk (
  .clk(clk),
  .rst_n(rst_n),
  .avs_address(avs_address),
  .avs_read(avs_read),
  .avs_write(avs_write),
  .avs_writedata(avs_writedata),
  .avs_readdata(avs_readdata),
  .avs_waitrequest(avs_waitrequest),
  .irq_request(irq_request),
  .irq_ack(irq_ack),
  .global_irq_enable(global_irq_enable)
);

`default_nettype wire

// ### dv/test_rot_sub_skip_core.sv
`timescale 1ns/1ps
`default_nettype none
`include "rot_sub_skip_map.vh"

module test_rot_sub_skip_core;
  localparam int CD = 4;
  localparam int LIMIT = 20000;
  logic clk, rst_n, avs_read, avs_write, irq_request;
  logic [4:0] avs_address;
  logic [31:0] avs_writedata, avs_readdata, rd;
  logic avs_waitrequest, irq_ack, global_irq_enable;
  int miscompares, tests_run, cycles, stall, acks;
  logic [7:0] e_acc, e_mem;
  logic [4:0] e_st;
  logic e_skip;
  logic [7:0] sa [0:4] = '{8'h10, 8'h80, 8'h05, 8'h01, 8'h7F};
  logic [7:0] sb [0:4] = '{8'h01, 8'h01, 8'h05, 8'h02, 8'hFF};

  rot_sub_skip_core #(.CYCLE_DIV(8'h04)) u_rot_sub_skip_core (
    .clk(clk),
    .rst_n(rst_n),
    .avs_address(avs_address),
    .avs_read(avs_read),
    .avs_write(avs_write),
    .avs_writedata(avs_writedata),
    .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest),
    .irq_request(irq_request),
    .irq_ack(irq_ack),
    .global_irq_enable(global_irq_enable)
  );

  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (irq_ack === 1'b1)
      acks <= acks + 1;
    if (cycles == LIMIT) begin
      miscompares++;
      summarize();
    end
  end

  // --------------------
  // Shared tasks
  // --------------------
  task automatic summarize();
    $display("Comparisons %0d, mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
    tests_run++;
    if (got !== exp) begin
      miscompares++;
      $display("[ERR] %s expected %h seen %h", name, exp, got);
    end
  endtask

  // A request is held until waitrequest is sampled low; only the bench timeout cuts a hang.
  task automatic bus_xfer(input logic wr, input logic [4:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    avs_address <= a;
    avs_writedata <= d;
    if (wr)
      avs_write <= 1'b1;
    else
      avs_read <= 1'b1;
    @(posedge clk);
    while (avs_waitrequest !== 1'b0) begin
      n++;
      @(posedge clk);
    end
    rd = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    stall = n;
  endtask

  task automatic model(input logic [4:0] op, input logic [2:0] b, input logic [7:0] imm,
                       input logic [7:0] acc, input logic [7:0] mem, input logic [4:0] st);
    logic [8:0] d;
    logic [4:0] h;
    logic [7:0] s;
    logic bin;
    e_acc = acc;
    e_mem = mem;
    e_st = st;
    s = (op == `OP_SUBTRACT_IMM) ? imm : mem;
    bin = (op == `OP_SUBTRACT_WITH_BORROW || op == `OP_SUBTRACT_WITH_BORROW_TO_MEM) ? ~st[0] : 1'b0;
    d = {1'b0, acc} - {1'b0, s} - {8'h00, bin};
    h = {1'b0, acc[3:0]} - {1'b0, s[3:0]} - {4'h0, bin};
    case (op)
      `OP_ROTATE_LEFT: e_mem = {mem[6:0], mem[7]};
      `OP_ROTATE_LEFT_TO_ACC: e_acc = {mem[6:0], mem[7]};
      `OP_ROTATE_LEFT_THRU_CARRY: e_mem = {mem[6:0], st[0]};
      `OP_ROTATE_LEFT_THRU_CARRY_TO_ACC: e_acc = {mem[6:0], st[0]};
      `OP_ROTATE_RIGHT: e_mem = {mem[0], mem[7:1]};
      `OP_ROTATE_RIGHT_TO_ACC: e_acc = {mem[0], mem[7:1]};
      `OP_ROTATE_RIGHT_THRU_CARRY: e_mem = {st[0], mem[7:1]};
      `OP_ROTATE_RIGHT_THRU_CARRY_TO_ACC: e_acc = {st[0], mem[7:1]};
      `OP_SUBTRACT_WITH_BORROW_TO_MEM, `OP_SUBTRACT_TO_MEM: e_mem = d[7:0];
      `OP_SUBTRACT_WITH_BORROW, `OP_SUBTRACT_MEM, `OP_SUBTRACT_IMM: e_acc = d[7:0];
      `OP_DECREMENT_SKIP_ZERO: e_mem = mem - 8'h01;
      `OP_DECREMENT_SKIP_ZERO_TO_ACC: e_acc = mem - 8'h01;
      `OP_INCREMENT_SKIP_ZERO: e_mem = mem + 8'h01;
      `OP_INCREMENT_SKIP_ZERO_TO_ACC: e_acc = mem + 8'h01;
      `OP_SET_BYTE: e_mem = 8'hFF;
      `OP_SET_BIT: e_mem = mem | (8'h01 << b);
      default: ;
    endcase
    if (op == `OP_ROTATE_LEFT_THRU_CARRY || op == `OP_ROTATE_LEFT_THRU_CARRY_TO_ACC)
      e_st[0] = mem[7];
    if (op == `OP_ROTATE_RIGHT_THRU_CARRY || op == `OP_ROTATE_RIGHT_THRU_CARRY_TO_ACC)
      e_st[0] = mem[0];
    if (op >= `OP_SUBTRACT_WITH_BORROW && op <= `OP_SUBTRACT_IMM)
      e_st[3:0] = {(acc[7] != s[7]) && (d[7] != acc[7]), d[7:0] == 8'h00, ~h[4], ~d[8]};
    e_skip = (op == `OP_DECREMENT_SKIP_ZERO || op == `OP_DECREMENT_SKIP_ZERO_TO_ACC) ? (mem == 8'h01) :
             (op == `OP_INCREMENT_SKIP_ZERO || op == `OP_INCREMENT_SKIP_ZERO_TO_ACC) ? (mem == 8'hFF) :
             (op == `OP_SKIP_BIT_NONZERO) ? mem[b] : 1'b0;
  endtask

  // The write after the launch stalls until the instruction ends, which times it.
  task automatic run_op(input logic [4:0] op, input logic [2:0] b, input logic [7:0] imm,
                        input logic [7:0] acc, input logic [7:0] mem, input logic [4:0] st);
    model(op, b, imm, acc, mem, st);
    bus_xfer(1'b1, `OFS_ACC, {24'h000000, acc});
    bus_xfer(1'b1, `OFS_STATUS, {27'h0, st});
    bus_xfer(1'b1, `OFS_MEM_ADDR, 32'h00000005);
    bus_xfer(1'b1, `OFS_MEM_DATA, {24'h000000, mem});
    bus_xfer(1'b1, `OFS_PC, 32'h00000100);
    bus_xfer(1'b1, `OFS_EXEC, {10'h0, 6'h05, imm, b, op});
    bus_xfer(1'b1, `OFS_MEM_ADDR, 32'h00000005);
    check("skip stall", {31'h0, e_skip}, {31'h0, stall >= CD});
    bus_xfer(1'b0, `OFS_ACC, 32'h00000000);
    check("acc", {24'h000000, e_acc}, rd);
    bus_xfer(1'b0, `OFS_MEM_DATA, 32'h00000000);
    check("mem", {24'h000000, e_mem}, rd);
    bus_xfer(1'b0, `OFS_STATUS, 32'h00000000);
    check("status", {22'h0, e_skip, 1'b0, 3'h0, e_st}, rd & 32'h0000031F);
    bus_xfer(1'b0, `OFS_PC, 32'h00000000);
    check("pc", e_skip ? 32'h00000102 : 32'h00000101, rd);
  endtask

  task automatic ret_op(input logic [4:0] op);
    bus_xfer(1'b1, `OFS_EXEC, {16'h0000, 8'h5A, 3'h0, op});
    bus_xfer(1'b1, `OFS_MEM_ADDR, 32'h00000005);
    bus_xfer(1'b0, `OFS_PC, 32'h00000000);
  endtask

  // --------------------
  // Test sequence
  // --------------------
  initial begin
    rst_n = 1'b0;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_address = 5'h00;
    avs_writedata = 32'h00000000;
    irq_request = 1'b0;
    miscompares = 0;
    tests_run = 0;
    cycles = 0;
    acks = 0;
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    for (int i = 2; i <= 9; i++) begin
      run_op(5'(i), 3'h0, 8'h00, 8'h3C, 8'h81, 5'h0A);
      run_op(5'(i), 3'h0, 8'h00, 8'h3C, 8'h42, 5'h15);
    end
    for (int i = 0; i < 5; i++) begin
      run_op(5'(10 + i), 3'h0, sb[i], sa[i], sb[i], 5'h00);
      run_op(5'(10 + i), 3'h0, sb[i], sa[i], sb[i], 5'h01);
    end
    run_op(`OP_DECREMENT_SKIP_ZERO, 3'h0, 8'h00, 8'h3C, 8'h01, 5'h0A);
    run_op(`OP_DECREMENT_SKIP_ZERO, 3'h0, 8'h00, 8'h3C, 8'h00, 5'h0A);
    run_op(`OP_DECREMENT_SKIP_ZERO_TO_ACC, 3'h0, 8'h00, 8'h3C, 8'h01, 5'h05);
    run_op(`OP_DECREMENT_SKIP_ZERO_TO_ACC, 3'h0, 8'h00, 8'h3C, 8'h10, 5'h05);
    run_op(`OP_INCREMENT_SKIP_ZERO, 3'h0, 8'h00, 8'h3C, 8'hFF, 5'h0A);
    run_op(`OP_INCREMENT_SKIP_ZERO, 3'h0, 8'h00, 8'h3C, 8'h7F, 5'h0A);
    run_op(`OP_INCREMENT_SKIP_ZERO_TO_ACC, 3'h0, 8'h00, 8'h3C, 8'hFF, 5'h15);
    run_op(`OP_INCREMENT_SKIP_ZERO_TO_ACC, 3'h0, 8'h00, 8'h3C, 8'h05, 5'h15);
    run_op(`OP_SET_BYTE, 3'h0, 8'h00, 8'h3C, 8'h12, 5'h15);
    run_op(`OP_SET_BIT, 3'h5, 8'h00, 8'h3C, 8'h00, 5'h0A);
    run_op(`OP_SET_BIT, 3'h7, 8'h00, 8'h3C, 8'h81, 5'h15);
    run_op(`OP_SKIP_BIT_NONZERO, 3'h7, 8'h00, 8'h3C, 8'h80, 5'h0A);
    run_op(`OP_SKIP_BIT_NONZERO, 3'h0, 8'h00, 8'h3C, 8'hFE, 5'h0A);
    bus_xfer(1'b1, `OFS_STACK_PUSH, 32'h00000123);
    bus_xfer(1'b1, `OFS_STACK_PUSH, 32'h00000456);
    bus_xfer(1'b1, `OFS_STACK_PUSH, 32'h00000789);
    bus_xfer(1'b0, `OFS_STACK_PUSH, 32'h00000000);
    check("push read", 32'h00000000, rd);
    bus_xfer(1'b1, `OFS_STATUS, 32'h0000000F);
    ret_op(`OP_RETURN_LOAD_IMM);
    check("ret pc", 32'h00000789, rd);
    bus_xfer(1'b0, `OFS_ACC, 32'h00000000);
    check("ret acc", 32'h0000005A, rd);
    bus_xfer(1'b0, `OFS_STATUS, 32'h00000000);
    check("ret flags", 32'h0000000F, rd & 32'h0000001F);
    ret_op(`OP_RETURN_FROM_IRQ);
    check("return_from_irq pc", 32'h00000456, rd);
    bus_xfer(1'b0, `OFS_STATUS, 32'h00000000);
    check("return_from_irq flags", 32'h0000001F, rd & 32'h0000001F);
    check("gie pin", 32'h00000001, {31'h0, global_irq_enable});
    bus_xfer(1'b1, `OFS_STATUS, 32'h0000000F);
    irq_request <= 1'b1;
    ret_op(`OP_RETURN_FROM_IRQ);
    check("irq pc", 32'h00000004, rd);
    bus_xfer(1'b0, `OFS_STACK_PTR, 32'h00000000);
    check("irq sp", 32'h00000001, rd);
    bus_xfer(1'b0, `OFS_STATUS, 32'h00000000);
    check("irq flags", 32'h0000000F, rd & 32'h0000001F);
    check("irq ack", 32'h00000001, acks);
    irq_request <= 1'b0;
    summarize();
  end
endmodule

`default_nettype wire
